// [pkg/lapc_cfg.svh]
// Constants for the axis position command block.
// Assumes inclusion by the core module only.
`ifndef LAPC_CFG_SVH
`define LAPC_CFG_SVH
`define LAPC_CMD_FRAME_ID   8'h20
`define LAPC_STAT_FRAME_ID  8'h21
`define LAPC_POS_MIN        16'hC000
`define LAPC_POS_MAX        16'h3FFF
`define LAPC_ADDR_CTRL      12'h000
`define LAPC_ADDR_HOME_TGT  12'h004
`define LAPC_ADDR_STALL_POS 12'h008
`define LAPC_ADDR_RATE_DIV  12'h00C
`define LAPC_ADDR_STATUS    12'h010
`define LAPC_ADDR_POSITION  12'h014
`define LAPC_ADDR_ERR_SET   12'h018
`define LAPC_ADDR_CMD       12'h01C
`define LAPC_RATE_DIV_RST   16'h0064
`define LAPC_INIT_CYCLES    4'h4
`define LAPC_FLD_RATE_LSB   16
`define LAPC_FLD_ERR_CLR    24
`define LAPC_FLD_INIT       25
`define LAPC_FLD_HOME       26
`define LAPC_FLD_LAMP       27
`endif

// [pkg/lapc_pkg.sv]
// Types for the axis position command block.
// Assumes lapc_cfg.svh on the include path.
package lapc_pkg;
  typedef struct packed {
    logic [15:0] position;
    logic [7:0]  step_rate;
    logic        error_clear;
    logic        app_init;
    logic        homing;
    logic        lamp;
  } lapc_cmd_t;
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_MOVE = 4'b0100,
    ST_HOME = 4'b1000
  } lapc_state_t;
endpackage

// [core/lapc_axis.sv]
// Axis command acceptor: decodes frames, runs position and homing control.
// Assumes frames arrive already checked, synchronous to mclk_in.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "lapc_cfg.svh"
module lapc_axis #(
  parameter logic [7:0] CMD_ID  = `LAPC_CMD_FRAME_ID,
  parameter logic [7:0] STAT_ID = `LAPC_STAT_FRAME_ID
) (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        frame_valid_in,
  input  wire logic        frame_crc_ok_in,
  input  wire logic [7:0]  frame_id_in,
  input  wire logic [63:0] frame_data_in,
  input  wire logic        resp_req_in,
  input  wire logic [7:0]  resp_id_in,
  output logic             resp_valid_out,
  output logic      [15:0] actual_position_signal_out,
  output logic      [7:0]  actual_step_rate_out,
  output logic             step_out,
  output logic             dir_out,
  output logic             lamp_switch_out
);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] clamp_pos(input logic [15:0] v);
    if ($signed(v) > $signed(`LAPC_POS_MAX)) clamp_pos = `LAPC_POS_MAX;
    else if ($signed(v) < $signed(`LAPC_POS_MIN)) clamp_pos = `LAPC_POS_MIN;
    else clamp_pos = v;
  endfunction

  // ==========================================================
  // Registers
  lapc_pkg::lapc_cmd_t  cmd_q;
  lapc_pkg::lapc_state_t state_q;
  logic        accept_en_q;
  logic [15:0] home_tgt_q;
  logic [15:0] stall_pos_q;
  logic [15:0] rate_div_q;
  logic [15:0] pos_q;
  logic [7:0]  rate_q;
  logic [15:0] tick_q;
  logic [3:0]  init_cnt_q;
  logic [7:0]  err_q;
  logic        cmd_pulse_q;
  logic        access;
  logic        wr;
  logic        accept;
  logic        tick;
  logic        mapped;
  logic [15:0] goal;

  assign access = psel_in && penable_in;
  assign wr     = access && pwrite_in && pready_out;
  assign accept = frame_valid_in && frame_crc_ok_in && accept_en_q
                  && (frame_id_in == CMD_ID);
  assign tick   = (tick_q == rate_div_q) && (rate_q != 8'h00);
  assign goal   = (state_q == lapc_pkg::ST_HOME) ? home_tgt_q
                                                : cmd_q.position;
  assign mapped = (paddr_in == `LAPC_ADDR_CTRL)
               || (paddr_in == `LAPC_ADDR_HOME_TGT)
               || (paddr_in == `LAPC_ADDR_STALL_POS)
               || (paddr_in == `LAPC_ADDR_RATE_DIV)
               || (paddr_in == `LAPC_ADDR_STATUS)
               || (paddr_in == `LAPC_ADDR_POSITION)
               || (paddr_in == `LAPC_ADDR_ERR_SET)
               || (paddr_in == `LAPC_ADDR_CMD);

  // ==========================================================
  // Configuration registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      accept_en_q <= 1'b1;
      home_tgt_q  <= 16'h0000;
      stall_pos_q <= 16'h0000;
      rate_div_q  <= `LAPC_RATE_DIV_RST;
    end else if (wr) begin
      case (paddr_in)
        `LAPC_ADDR_CTRL:      accept_en_q <= pwdata_in[0];
        `LAPC_ADDR_HOME_TGT:  home_tgt_q  <= pwdata_in[15:0];
        `LAPC_ADDR_STALL_POS: stall_pos_q <= pwdata_in[15:0];
        `LAPC_ADDR_RATE_DIV:  rate_div_q  <= pwdata_in[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Command latch
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cmd_q       <= '0;
      cmd_pulse_q <= 1'b0;
    end else begin
      cmd_pulse_q <= accept;
      if (accept) begin
        cmd_q.position    <= clamp_pos(frame_data_in[15:0]);
        cmd_q.step_rate   <= frame_data_in[`LAPC_FLD_RATE_LSB +: 8];
        cmd_q.error_clear <= frame_data_in[`LAPC_FLD_ERR_CLR];
        cmd_q.app_init    <= frame_data_in[`LAPC_FLD_INIT];
        cmd_q.homing      <= frame_data_in[`LAPC_FLD_HOME];
        cmd_q.lamp        <= frame_data_in[`LAPC_FLD_LAMP];
      end
    end
  end

  // ==========================================================
  // Error flags, APB register set wins over frame clear
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      err_q <= 8'h00;
    end else if (wr && paddr_in == `LAPC_ADDR_ERR_SET) begin
      err_q <= err_q | pwdata_in[7:0];
    end else if (cmd_pulse_q && cmd_q.error_clear) begin
      err_q <= 8'h00;
    end
  end

  // ==========================================================
  // Control state machine
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q    <= lapc_pkg::ST_INIT;
      init_cnt_q <= 4'h0;
    end else if (cmd_pulse_q && cmd_q.app_init) begin
      state_q    <= lapc_pkg::ST_INIT;
      init_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        lapc_pkg::ST_INIT: begin
          init_cnt_q <= init_cnt_q + 4'h1;
          if (init_cnt_q == `LAPC_INIT_CYCLES) state_q <= lapc_pkg::ST_IDLE;
        end
        lapc_pkg::ST_IDLE, lapc_pkg::ST_MOVE: begin
          if (cmd_pulse_q && cmd_q.homing) state_q <= lapc_pkg::ST_HOME;
          else if (pos_q != cmd_q.position) state_q <= lapc_pkg::ST_MOVE;
          else state_q <= lapc_pkg::ST_IDLE;
        end
        lapc_pkg::ST_HOME: begin
          if (pos_q == home_tgt_q) state_q <= lapc_pkg::ST_IDLE;
        end
        default: state_q <= lapc_pkg::ST_INIT;
      endcase
    end
  end

  // ==========================================================
  // Step rate ramp and step timer
  always_ff @(posedge mclk_in) begin
    if (srst_in || state_q == lapc_pkg::ST_INIT) begin
      rate_q <= 8'h00;
      tick_q <= 16'h0000;
    end else begin
      // The timer restarts at the divider so it never runs the long way round.
      tick_q <= (tick_q >= rate_div_q) ? 16'h0000 : tick_q + 16'h0001;
      if (tick_q == rate_div_q || rate_q == 8'h00) begin
        if (state_q == lapc_pkg::ST_IDLE) rate_q <= 8'h00;
        else if (rate_q < cmd_q.step_rate) rate_q <= rate_q + 8'h01;
        else if (rate_q > cmd_q.step_rate) rate_q <= rate_q - 8'h01;
      end
    end
  end

  // ==========================================================
  // Position counter
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pos_q    <= 16'h0000;
      step_out <= 1'b0;
      dir_out  <= 1'b0;
    end else begin
      step_out <= 1'b0;
      // Counter is held through initialisation.
      if (state_q == lapc_pkg::ST_HOME && pos_q == home_tgt_q) begin
        pos_q <= stall_pos_q;
      end else if (tick && pos_q != goal
                   && state_q != lapc_pkg::ST_INIT) begin
        step_out <= 1'b1;
        dir_out  <= $signed(goal) > $signed(pos_q);
        pos_q    <= ($signed(goal) > $signed(pos_q)) ?
                    pos_q + 16'h0001 : pos_q - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Outputs and status frame
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      lamp_switch_out            <= 1'b0;
      resp_valid_out             <= 1'b0;
      actual_position_signal_out <= 16'h0000;
      actual_step_rate_out       <= 8'h00;
    end else begin
      lamp_switch_out            <= cmd_q.lamp;
      resp_valid_out             <= resp_req_in
                                    && resp_id_in == STAT_ID;
      actual_position_signal_out <= pos_q;
      actual_step_rate_out       <= rate_q;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= access && !pready_out;
      pslverr_out <= access && !pready_out && !mapped;
      prdata_out  <= 32'h0000_0000;
      if (access && !pready_out && !pwrite_in) begin
        case (paddr_in)
          `LAPC_ADDR_CTRL:      prdata_out <= {31'h0, accept_en_q};
          `LAPC_ADDR_HOME_TGT:  prdata_out <= {16'h0, home_tgt_q};
          `LAPC_ADDR_STALL_POS: prdata_out <= {16'h0, stall_pos_q};
          `LAPC_ADDR_RATE_DIV:  prdata_out <= {16'h0, rate_div_q};
          `LAPC_ADDR_STATUS:    prdata_out <= {16'h0, err_q, rate_q};
          `LAPC_ADDR_POSITION:  prdata_out <= {16'h0, pos_q};
          `LAPC_ADDR_ERR_SET:   prdata_out <= {24'h0, err_q};
          `LAPC_ADDR_CMD:       prdata_out <= {cmd_q, 4'h0};
          default:              prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  a_reject_bad_frame: assert property (@(posedge mclk_in) disable iff (srst_in)
    frame_valid_in && !frame_crc_ok_in |=> $stable(cmd_q))
    else $error("Command changed by bad frame.");
  a_init_entry: assert property (@(posedge mclk_in) disable iff (srst_in)
    cmd_pulse_q && cmd_q.app_init |=> state_q == lapc_pkg::ST_INIT)
    else $error("Init not entered.");
  a_init_keeps_pos: assert property (@(posedge mclk_in) disable iff (srst_in)
    state_q == lapc_pkg::ST_INIT && $past(state_q) == lapc_pkg::ST_INIT
    |-> $stable(pos_q))
    else $error("Counter moved in init.");
  a_home_load: assert property (@(posedge mclk_in) disable iff (srst_in)
    state_q == lapc_pkg::ST_HOME && pos_q == home_tgt_q
    |=> pos_q == $past(stall_pos_q))
    else $error("End stop value not loaded.");
  a_err_clear: assert property (@(posedge mclk_in) disable iff (srst_in)
    cmd_pulse_q && cmd_q.error_clear && !wr |=> err_q == 8'h00)
    else $error("Errors not cleared.");
  a_lamp_follow: assert property (@(posedge mclk_in) disable iff (srst_in)
    accept ##2 1 |-> lamp_switch_out == $past(frame_data_in[27], 2))
    else $error("Lamp switch wrong.");
  a_pos_range: assert property (@(posedge mclk_in) disable iff (srst_in)
    $signed(cmd_q.position) >= $signed(`LAPC_POS_MIN)
    && $signed(cmd_q.position) <= $signed(`LAPC_POS_MAX))
    else $error("Target out of range.");
  a_step_dir: assert property (@(posedge mclk_in) disable iff (srst_in)
    step_out |-> pos_q == $past(pos_q) + (dir_out ? 16'h0001 : 16'hFFFF))
    else $error("Counter missed a step.");
  a_ignore_off: assert property (@(posedge mclk_in) disable iff (srst_in)
    !accept_en_q && !wr |=> $stable(cmd_q))
    else $error("Frame taken while not acceptor.");
  a_status_pos: assert property (@(posedge mclk_in) disable iff (srst_in)
    actual_position_signal_out == $past(pos_q))
    else $error("Status position stale.");

  // ==========================================================
  // Sequences
  sequence s_home_hit;
    state_q == lapc_pkg::ST_HOME && pos_q == home_tgt_q
    && !(cmd_pulse_q && cmd_q.app_init);
  endsequence
  sequence s_home_exit;
    state_q == lapc_pkg::ST_IDLE;
  endsequence
  sequence s_status_hdr;
    resp_req_in && resp_id_in == STAT_ID;
  endsequence

  // ==========================================================
  // More checks
  a_home_exit: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_home_hit |=> s_home_exit)
    else $error("Homing did not finish.");
  a_resp_answer: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_status_hdr |=> resp_valid_out)
    else $error("Status header not answered.");
  a_resp_only_stat: assert property (@(posedge mclk_in) disable iff (srst_in)
    resp_valid_out |-> $past(resp_req_in) && $past(resp_id_in) == STAT_ID)
    else $error("Answered a foreign frame.");
  a_pready_wait: assert property (@(posedge mclk_in) disable iff (srst_in)
    access && !pready_out |=> pready_out)
    else $error("Bus answer missing.");
  a_pready_pulse: assert property (@(posedge mclk_in) disable iff (srst_in)
    pready_out |=> !pready_out)
    else $error("Bus answer too long.");
  a_pslverr_ready: assert property (@(posedge mclk_in) disable iff (srst_in)
    pslverr_out |-> pready_out)
    else $error("Error without answer.");
  a_rate_ramp: assert property (@(posedge mclk_in) disable iff (srst_in)
    $changed(rate_q) |-> rate_q == $past(rate_q) + 8'h01
    || rate_q == $past(rate_q) - 8'h01 || rate_q == 8'h00)
    else $error("Rate jumped.");
  a_step_rate: assert property (@(posedge mclk_in) disable iff (srst_in)
    step_out |-> $past(rate_q) != 8'h00)
    else $error("Step at zero rate.");
  a_init_no_step: assert property (@(posedge mclk_in) disable iff (srst_in)
    state_q == lapc_pkg::ST_INIT |=> !step_out)
    else $error("Step during init.");
  a_init_rate: assert property (@(posedge mclk_in) disable iff (srst_in)
    state_q == lapc_pkg::ST_INIT && $past(state_q) == lapc_pkg::ST_INIT
    |-> rate_q == 8'h00)
    else $error("Rate kept in init.");
  a_home_entry: assert property (@(posedge mclk_in) disable iff (srst_in)
    cmd_pulse_q && cmd_q.homing && !cmd_q.app_init
    && (state_q == lapc_pkg::ST_IDLE || state_q == lapc_pkg::ST_MOVE)
    |=> state_q == lapc_pkg::ST_HOME)
    else $error("Homing not started.");
  a_cmd_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
    !accept |=> $stable(cmd_q))
    else $error("Command changed without a frame.");
endmodule

// [tb/lapc_lin_master.sv]
// LIN master stand-in: sends command frames and response headers.
// Assumes its tasks are called by the bench on the rising clock edge.
`timescale 1ns/1ns
module lapc_lin_master (
  input  wire logic        mclk_in,
  output logic             fv_out,
  output logic             crc_out,
  output logic [7:0]       id_out,
  output logic [63:0]      data_out,
  output logic             rq_out,
  output logic [7:0]       rid_out
);
  initial begin
    {fv_out, crc_out, rq_out} = 3'h0;
    {id_out, rid_out} = 16'h0000;
    data_out = 64'h0;
  end
  // The master provides command frames and never answers them.
  // Released lines show the inverse of the last value.
  task automatic send(input logic [7:0] id, input logic [63:0] d,
                      input logic ok);
    @(posedge mclk_in);
    {fv_out, crc_out, id_out, data_out} <= {1'b1, ok, id, d};
    @(posedge mclk_in);
    {fv_out, crc_out, id_out, data_out} <= {1'b0, ~ok, ~id, ~d};
  endtask
  task automatic header(input logic [7:0] id);
    @(posedge mclk_in);
    {rq_out, rid_out} <= {1'b1, id};
    @(posedge mclk_in);
    {rq_out, rid_out} <= {1'b0, ~id};
  endtask
endmodule

// [tb/lin_axis_position_command_tb.sv]
// Bench for the axis command block with an APB master and LIN model.
// Assumes the core and package are compiled first.
`timescale 1ns/1ns
module lin_axis_position_command_tb;
  logic        clk, rst, psel, pen, pwr, fv, crc, rq, rv, stp, dir, lamp;
  logic        prdy, perr;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [7:0]  fid, rid, rate;
  logic [63:0] fd;
  logic [15:0] pos;
  int          mismatches, total_checks, n;
  lapc_axis i_dut (.mclk_in(clk), .srst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .frame_valid_in(fv), .frame_crc_ok_in(crc), .frame_id_in(fid),
    .frame_data_in(fd), .resp_req_in(rq), .resp_id_in(rid),
    .resp_valid_out(rv), .actual_position_signal_out(pos),
    .actual_step_rate_out(rate), .step_out(stp), .dir_out(dir),
    .lamp_switch_out(lamp));
  lapc_lin_master i_lin (.mclk_in(clk), .fv_out(fv), .crc_out(crc),
    .id_out(fid), .data_out(fd), .rq_out(rq), .rid_out(rid));
  // ==========================================
  // Shared tasks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic e = 1'b0);
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1);
    rd = prd;
    chk({31'h0, perr}, {31'h0, e});
    {psel, pen} <= 2'b00;
  endtask
  function automatic logic [63:0] cmd(logic [15:0] p, logic [7:0] r,
                                      logic [3:0] f);
    return {36'h0, f, r, p};
  endfunction
  task automatic wait_pos(input logic [15:0] p, output int steps);
    steps = 0;
    for (n = 0; n < 1000 && pos !== p; n++) begin
      @(posedge clk);
      #1 steps += (stp === 1'b1);
    end
    chk(pos, p);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_frames;
    i_lin.send(8'h20, cmd(16'h0000, 8'h00, 4'h8), 1'b1);
    repeat (2) @(posedge clk);
    #1 chk(lamp, 1'b1);
    i_lin.send(8'h20, cmd(16'h1234, 8'h00, 4'h0), 1'b0);
    i_lin.send(8'h23, cmd(16'h1234, 8'h00, 4'h0), 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    i_lin.send(8'h20, cmd(16'h1234, 8'h00, 4'h0), 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(lamp, 1'b1);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h00000010);
    apb(1'b1, 12'h000, 32'h1);
    i_lin.send(8'h20, cmd(16'h0000, 8'h00, 4'h0), 1'b1);
    repeat (2) @(posedge clk);
    #1 chk(lamp, 1'b0);
    $display("test frames done");
  endtask
  task automatic t_errs;
    apb(1'b1, 12'h018, 32'hFF);
    i_lin.send(8'h20, cmd(16'h0000, 8'h00, 4'h0), 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd & 32'hFF00, 32'hFF00);
    i_lin.send(8'h20, cmd(16'h0000, 8'h00, 4'h1), 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd & 32'hFF00, 32'h0);
    $display("test errors done");
  endtask
  task automatic t_move_home;
    int s;
    apb(1'b1, 12'h00C, 32'h2);
    i_lin.send(8'h20, cmd(16'h0005, 8'h03, 4'h0), 1'b1);
    wait_pos(16'h0005, s);
    chk(s, 5);
    apb(1'b1, 12'h004, 32'hFFFD);
    apb(1'b1, 12'h008, 32'h10);
    i_lin.send(8'h20, cmd(16'h0010, 8'h03, 4'h4), 1'b1);
    wait_pos(16'hFFFD, s);
    chk(s, 8);
    repeat (10) @(posedge clk);
    #1 chk(pos, 16'h0010);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h10);
    $display("test move and homing done");
  endtask
  task automatic t_resp_init;
    logic [15:0] p;
    i_lin.header(8'h21);
    #1 chk(rv, 1'b1);
    i_lin.header(8'h20);
    repeat (2) @(posedge clk);
    #1 chk(rv, 1'b0);
    i_lin.send(8'h20, cmd(16'h0040, 8'h03, 4'h0), 1'b1);
    repeat (40) @(posedge clk);
    p = pos;
    i_lin.send(8'h20, cmd(16'h0040, 8'h03, 4'h2), 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(pos >= p && pos <= p + 16'h3, 1'b1);
    $display("test response and init done");
  endtask
  initial begin
    {rst, psel, pen, pwr, pa, pwd} = {4'h8, 12'h000, 32'h0};
    {mismatches, total_checks} = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h64);
    apb(1'b1, 12'h020, 32'h5, 1'b1);
    apb(1'b0, 12'h020, 32'h0, 1'b1);
    chk(rd, 32'h0);
    $display("test registers done");
    t_frames;
    t_errs;
    t_move_home;
    t_resp_init;
    tally_and_finish;
  end
  initial begin
    #(20 * 40000);
    mismatches++;
    tally_and_finish;
  end
endmodule
